/* inc/tus_pkg.sv */
// package: timing constants and sequencer states for the tape unload sequencer
package tus_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    // tape-present trailing delay, in microseconds
    localparam int unsigned TAPE_TAIL_US = 200;
    localparam int unsigned TAPE_TAIL_CYC = (TAPE_TAIL_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned TAIL_W = 12;
    localparam logic [TAIL_W-1:0] TAIL_LOAD = TAIL_W'(TAPE_TAIL_CYC - 1);
    localparam logic [TAIL_W-1:0] TAIL_ZERO = 12'h000;

    typedef enum logic [2:0] {
        TUS_IDLE = 3'b000,
        TUS_RIGHT_OUT = 3'b001,
        TUS_PNEU_DROP = 3'b010,
        TUS_LEFT_TAKEUP = 3'b011,
        TUS_REWIND = 3'b100,
        TUS_TAIL = 3'b101
    } tus_state_t;
endpackage

/* inc/tus_tail_if.sv */
// interface: tape-present falling-edge delay handshake
`timescale 1ns/10ps
`default_nettype none
interface tus_tail_if;
    logic sensor;
    logic media;
    modport owner (input sensor, output media);
    modport user (output sensor, input media);
endinterface
`default_nettype wire

/* logic/tus_tail_delay.sv */
// module: media detect with delayed release after the tape end marker clears
`timescale 1ns/10ps
`default_nettype none
module tus_tail_delay
    import tus_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    tus_tail_if.owner tif
);
    logic [TAIL_W-1:0] count;
    logic [TAIL_W-1:0] next_count;
    logic media;
    logic next_media;

    always_comb begin
        next_count = count;
        next_media = media;
        if (tif.sensor) begin
            next_media = 1'b1;
            next_count = TAIL_LOAD;
        end else if (media) begin
            // hold presence so the right reel finishes winding
            if (count == TAIL_ZERO) begin
                next_media = 1'b0;
            end else begin
                next_count = count - 12'h001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            count <= TAIL_ZERO;
            media <= 1'b0;
        end else begin
            count <= next_count;
            media <= next_media;
        end
    end

    assign tif.media = media;

    AST_TAIL_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
        $fell(tif.sensor) && media |-> media [*8])
        else $error("media dropped too soon");
endmodule
`default_nettype wire

/* logic/tus_unload_seq.sv */
// module: tape unload sequencer with reel, valve, pneumatic and window control
`timescale 1ns/10ps
`default_nettype none
// Operation
// - eject press sets in-progress, rewind flag and operator-initiated
// - while in progress, right reel turns counterclockwise first
// - pneumatics-on: right reel runs until left top switch clears, then transfer valve
// - pneumatics-on: columns empty stops right reel, left reel takes up clockwise
// - pneumatics-on: on tension, both reels counterclockwise until tape on right reel
// - early-drop: right column switch transfer drops pneumatics
// - early-drop: columns empty when both lower column switches transferred
// - early-drop: columns empty energizes valve, restarts pneumatics, left reel clockwise
// - early-drop: tension turns pneumatics off, both reels counterclockwise
// - tension only counts when tape taut and vacuum present
// - media detected drops when tape end passes marker sensor during rewind
// - media loss is delayed so tape fully winds before reels stop
// - column-emptied line low until right column empty, high until left empty
// - pressure sense reported low whenever pneumatics off
// - thread or reset press energizes relay, raises window to top limit
// - lowering releases relay, reverses motor, ignores top limit, stops at bottom
// - safety bail releases relay so window lowers
// - eject or host unload releases relay; lowering waits for sequence end
// - eject done when columns empty and media absent
// - pneumatics-on: pneumatic motor runs while in progress; done clears in progress
module tus_unload_seq
    import tus_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic eject_button,
    input wire logic host_unload_cmd,
    input wire logic thread_button,
    input wire logic reset_button,
    input wire logic early_drop_cfg,
    input wire logic left_col_top_vac_sw,
    input wire logic right_col_vac_sw_a,
    input wire logic left_col_low_vac_sw,
    input wire logic right_col_low_vac_sw,
    input wire logic tension_sw,
    input wire logic vacuum_present,
    input wire logic pressure_sw,
    input wire logic tape_end_marker_sensor,
    input wire logic door_top_limit_sw,
    input wire logic door_bottom_limit_sw,
    input wire logic safety_bail_sw,
    output logic eject_in_progress,
    output logic eject_rewind_flag,
    output logic operator_initiated,
    output logic right_reel_ccw,
    output logic left_reel_cw,
    output logic left_reel_ccw,
    output logic transfer_valve,
    output logic pneumatic_motor,
    output logic columns_empty,
    output logic col_emptied_line,
    output logic pressure_sense,
    output logic media_detected,
    output logic eject_done,
    output logic window_relay,
    output logic window_motor_up,
    output logic window_motor_down
);
    tus_tail_if tif();
    tus_tail_delay u_tail (
        .ref_clk(ref_clk),
        .reset(reset),
        .tif(tif)
    );
    assign tif.sensor = tape_end_marker_sensor;

    tus_state_t state, next_state;
    logic variant_drop, next_variant_drop;
    logic next_in_prog, next_rew, next_oper;
    logic next_rr_ccw, next_lr_cw, next_lr_ccw, next_valve, next_pneu;
    logic next_cols_empty, next_col_line, next_press, next_media, next_done;
    logic reel_tension_sensed;
    logic lower_pending, next_lower_pending;
    logic next_relay, next_up, next_down;
    logic start;

    function automatic logic tension_ok(input logic sw, input logic vac);
        return sw & vac;
    endfunction

    assign reel_tension_sensed = tension_ok(tension_sw, vacuum_present);
    assign start = (eject_button | host_unload_cmd) & ~eject_in_progress;

    always_comb begin
        next_state = state;
        next_variant_drop = variant_drop;
        next_in_prog = eject_in_progress;
        next_rew = eject_rewind_flag;
        next_oper = operator_initiated;
        next_done = 1'b0;
        next_cols_empty = columns_empty;
        case (state)
            TUS_IDLE: begin
                next_cols_empty = 1'b0;
                if (start) begin
                    next_in_prog = 1'b1;
                    next_rew = 1'b1;
                    next_oper = eject_button;
                    next_variant_drop = early_drop_cfg;
                    next_state = TUS_RIGHT_OUT;
                end
            end
            TUS_RIGHT_OUT: begin
                if (!variant_drop && left_col_top_vac_sw) begin
                    next_state = TUS_PNEU_DROP;
                end else if (variant_drop && right_col_vac_sw_a) begin
                    next_state = TUS_PNEU_DROP;
                end
            end
            TUS_PNEU_DROP: begin
                if (variant_drop ? (left_col_low_vac_sw & right_col_low_vac_sw) : ~vacuum_present) begin
                    next_cols_empty = 1'b1;
                    next_state = TUS_LEFT_TAKEUP;
                end
            end
            TUS_LEFT_TAKEUP: begin
                if (reel_tension_sensed) begin
                    next_state = TUS_REWIND;
                end
            end
            TUS_REWIND: begin
                if (!tif.media) begin
                    next_state = TUS_TAIL;
                end
            end
            TUS_TAIL: begin
                if (columns_empty && !tif.media) begin
                    next_done = 1'b1;
                    next_in_prog = 1'b0;
                    next_rew = 1'b0;
                    next_oper = 1'b0;
                    next_state = TUS_IDLE;
                end
            end
            default: next_state = TUS_IDLE;
        endcase
    end

    always_comb begin
        next_rr_ccw = (next_state == TUS_RIGHT_OUT) || (next_state == TUS_PNEU_DROP)
            || (next_state == TUS_REWIND);
        next_lr_cw = (next_state == TUS_LEFT_TAKEUP);
        next_lr_ccw = (next_state == TUS_REWIND);
        next_valve = (next_state == TUS_LEFT_TAKEUP) || (next_state == TUS_REWIND)
            || (!next_variant_drop && next_state == TUS_PNEU_DROP);
        if (next_variant_drop) begin
            next_pneu = (next_state == TUS_RIGHT_OUT) || (next_state == TUS_LEFT_TAKEUP);
        end else begin
            next_pneu = next_in_prog;
        end
        next_col_line = (next_state == TUS_PNEU_DROP)
            || (!next_variant_drop && next_state == TUS_RIGHT_OUT && right_col_vac_sw_a);
        next_press = next_pneu & pressure_sw;
        next_media = tif.media;
    end

    always_comb begin
        next_relay = window_relay;
        next_lower_pending = lower_pending;
        next_up = 1'b0;
        next_down = 1'b0;
        if (thread_button || reset_button) begin
            next_relay = 1'b1;
            next_lower_pending = 1'b0;
        end
        if (safety_bail_sw) begin
            next_relay = 1'b0;
        end
        if (eject_button || host_unload_cmd) begin
            next_relay = 1'b0;
            next_lower_pending = 1'b1;
        end
        if (next_relay) begin
            next_up = ~door_top_limit_sw;
        end else if (!next_lower_pending || next_done) begin
            next_down = ~door_bottom_limit_sw;
            if (door_bottom_limit_sw || next_done) begin
                next_lower_pending = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= TUS_IDLE;
            variant_drop <= 1'b0;
            eject_in_progress <= 1'b0;
            eject_rewind_flag <= 1'b0;
            operator_initiated <= 1'b0;
            right_reel_ccw <= 1'b0;
            left_reel_cw <= 1'b0;
            left_reel_ccw <= 1'b0;
            transfer_valve <= 1'b0;
            pneumatic_motor <= 1'b0;
            columns_empty <= 1'b0;
            col_emptied_line <= 1'b0;
            pressure_sense <= 1'b0;
            media_detected <= 1'b0;
            eject_done <= 1'b0;
            lower_pending <= 1'b0;
            window_relay <= 1'b0;
            window_motor_up <= 1'b0;
            window_motor_down <= 1'b0;
        end else begin
            state <= next_state;
            variant_drop <= next_variant_drop;
            eject_in_progress <= next_in_prog;
            eject_rewind_flag <= next_rew;
            operator_initiated <= next_oper;
            right_reel_ccw <= next_rr_ccw;
            left_reel_cw <= next_lr_cw;
            left_reel_ccw <= next_lr_ccw;
            transfer_valve <= next_valve;
            pneumatic_motor <= next_pneu;
            columns_empty <= next_cols_empty;
            col_emptied_line <= next_col_line;
            pressure_sense <= next_press;
            media_detected <= next_media;
            eject_done <= next_done;
            lower_pending <= next_lower_pending;
            window_relay <= next_relay;
            window_motor_up <= next_up;
            window_motor_down <= next_down;
        end
    end

    AST_START: assert property (@(posedge ref_clk) disable iff (reset)
        (state == TUS_IDLE) && eject_button && !eject_in_progress |=> eject_in_progress && operator_initiated)
        else $error("eject did not start sequence");
    AST_REW_FLAG: assert property (@(posedge ref_clk) disable iff (reset)
        eject_in_progress |-> eject_rewind_flag)
        else $error("rewind flag low during unload");
    AST_RIGHT_CCW: assert property (@(posedge ref_clk) disable iff (reset)
        (state == TUS_RIGHT_OUT) |-> right_reel_ccw || $past(state) == TUS_IDLE)
        else $error("right reel not ccw");
    AST_PNEU_VALVE: assert property (@(posedge ref_clk) disable iff (reset)
        !variant_drop && (state == TUS_PNEU_DROP) |-> transfer_valve && right_reel_ccw)
        else $error("valve not picked after left top switch");
    AST_PNEU_TAKE: assert property (@(posedge ref_clk) disable iff (reset)
        !variant_drop && (state == TUS_PNEU_DROP) && !vacuum_present
        |=> (state == TUS_LEFT_TAKEUP) && columns_empty && left_reel_cw)
        else $error("vacuum loss did not start left takeup");
    AST_TAKEUP: assert property (@(posedge ref_clk) disable iff (reset)
        (state == TUS_LEFT_TAKEUP) && $stable(state) |-> left_reel_cw && !right_reel_ccw && transfer_valve)
        else $error("left takeup drive wrong");
    AST_REWIND: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(state == TUS_REWIND) |-> right_reel_ccw && left_reel_ccw)
        else $error("rewind drive wrong");
    AST_DROP: assert property (@(posedge ref_clk) disable iff (reset)
        variant_drop && (state == TUS_PNEU_DROP) && $stable(state) |-> !pneumatic_motor)
        else $error("pneumatics not dropped");
    AST_COLS_EARLY: assert property (@(posedge ref_clk) disable iff (reset)
        variant_drop && (state == TUS_PNEU_DROP) && left_col_low_vac_sw && right_col_low_vac_sw |=> columns_empty)
        else $error("columns empty not set by lower switches");
    AST_EARLY_TAKE: assert property (@(posedge ref_clk) disable iff (reset)
        variant_drop && (state == TUS_LEFT_TAKEUP) |-> pneumatic_motor && transfer_valve && left_reel_cw)
        else $error("early-drop takeup drive wrong");
    AST_EARLY_REWIND: assert property (@(posedge ref_clk) disable iff (reset)
        variant_drop && (state == TUS_REWIND) |-> !pneumatic_motor && right_reel_ccw && left_reel_ccw)
        else $error("early-drop rewind drive wrong");
    AST_TENSION: assert property (@(posedge ref_clk) disable iff (reset)
        (state == TUS_LEFT_TAKEUP) && !(tension_sw && vacuum_present) |=> (state == TUS_LEFT_TAKEUP))
        else $error("takeup left without taut tape and vacuum");
    AST_MEDIA: assert property (@(posedge ref_clk) disable iff (reset)
        tape_end_marker_sensor |-> ##2 media_detected)
        else $error("media not detected with tape at sensor");
    AST_TAIL_STOP: assert property (@(posedge ref_clk) disable iff (reset)
        (state == TUS_TAIL) |-> !right_reel_ccw && !left_reel_ccw && !media_detected)
        else $error("reels still driven after media loss");
    AST_LINE: assert property (@(posedge ref_clk) disable iff (reset)
        col_emptied_line |-> eject_in_progress && !columns_empty)
        else $error("column line high outside column emptying");
    AST_PRESS: assert property (@(posedge ref_clk) disable iff (reset)
        !pneumatic_motor |-> !pressure_sense)
        else $error("pressure sense high with pneumatics off");
    AST_TOP: assert property (@(posedge ref_clk) disable iff (reset)
        window_motor_up |-> window_relay && !window_motor_down)
        else $error("window up drive without relay");
    AST_UP_STOP: assert property (@(posedge ref_clk) disable iff (reset)
        door_top_limit_sw |=> !window_motor_up)
        else $error("window up drive at top limit");
    AST_BOTTOM_STOP: assert property (@(posedge ref_clk) disable iff (reset)
        door_bottom_limit_sw |=> !window_motor_down)
        else $error("window down drive at bottom limit");
    AST_BAIL: assert property (@(posedge ref_clk) disable iff (reset)
        safety_bail_sw && !thread_button && !reset_button |=> !window_relay)
        else $error("bail did not release relay");
    AST_UNLOAD_RELAY: assert property (@(posedge ref_clk) disable iff (reset)
        eject_button || host_unload_cmd |=> !window_relay)
        else $error("unload request did not release relay");
    AST_DONE: assert property (@(posedge ref_clk) disable iff (reset)
        eject_done |-> !eject_in_progress && (state == TUS_IDLE) && !media_detected)
        else $error("done without clearing progress");
    AST_PNEU_ON: assert property (@(posedge ref_clk) disable iff (reset)
        !variant_drop && eject_in_progress && $stable(eject_in_progress) |-> pneumatic_motor)
        else $error("pneumatic motor off during unload");
    AST_VARIANT: assert property (@(posedge ref_clk) disable iff (reset)
        eject_in_progress && $stable(eject_in_progress) |-> $stable(variant_drop))
        else $error("variant changed during unload");
endmodule
`default_nettype wire

/* dv/tus_plant.sv */
// partner model: reel, column, pneumatic, tape marker and window mechanics
`timescale 1ns/10ps
`default_nettype none
module tus_plant (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic right_reel_ccw,
    input wire logic left_reel_cw,
    input wire logic left_reel_ccw,
    input wire logic transfer_valve,
    input wire logic pneumatic_motor,
    input wire logic window_motor_up,
    input wire logic window_motor_down,
    output logic left_col_top_vac_sw,
    output logic right_col_vac_sw_a,
    output logic left_col_low_vac_sw,
    output logic right_col_low_vac_sw,
    output logic tension_sw,
    output logic vacuum_present,
    output logic pressure_sw,
    output logic tape_end_marker_sensor,
    output logic door_top_limit_sw,
    output logic door_bottom_limit_sw
);
    int out_cnt, take_cnt, wind_cnt, pos;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            out_cnt <= 0;
            take_cnt <= 0;
            wind_cnt <= 0;
            pos <= 0;
            pressure_sw <= 1'b0;
        end else begin
            if (right_reel_ccw && !left_reel_ccw) out_cnt <= out_cnt + 1;
            if (left_reel_cw) take_cnt <= take_cnt + 1;
            if (right_reel_ccw && left_reel_ccw) wind_cnt <= wind_cnt + 1;
            if (window_motor_up && pos < 12) pos <= pos + 1;
            if (window_motor_down && pos > 0) pos <= pos - 1;
            // pressure lags the pump by a cycle
            pressure_sw <= pneumatic_motor;
        end
    end
    assign right_col_vac_sw_a = out_cnt >= 20;
    assign left_col_top_vac_sw = out_cnt >= 40;
    // column vacuum bleeds off once the valve moves, threading vacuum returns with takeup
    assign vacuum_present = pneumatic_motor && (!transfer_valve || left_reel_cw || left_reel_ccw);
    assign left_col_low_vac_sw = !vacuum_present && right_col_vac_sw_a;
    assign right_col_low_vac_sw = !vacuum_present && right_col_vac_sw_a;
    assign tension_sw = take_cnt >= 10;
    assign tape_end_marker_sensor = wind_cnt < 15;
    assign door_top_limit_sw = pos == 12;
    assign door_bottom_limit_sw = pos == 0;
endmodule
`default_nettype wire

/* dv/tus_unload_sequencer_bench.sv */
// testbench: unload in both variants, window control and reset
`timescale 1ns/10ps
`default_nettype none
module tus_unload_sequencer_bench;
    import tus_pkg::*;
    typedef struct packed {logic cfg; logic by_host; logic up_by_reset; logic exp_oper;} tus_row_t;
    localparam int LIM = 3000;
    logic ref_clk, reset, eject_button, host_unload_cmd, thread_button, reset_button, early_drop_cfg, safety_bail_sw;
    logic left_col_top_vac_sw, right_col_vac_sw_a, left_col_low_vac_sw, right_col_low_vac_sw, tension_sw;
    logic vacuum_present, pressure_sw, tape_end_marker_sensor, door_top_limit_sw, door_bottom_limit_sw;
    logic eject_in_progress, eject_rewind_flag, operator_initiated, right_reel_ccw, left_reel_cw, left_reel_ccw;
    logic transfer_valve, pneumatic_motor, columns_empty, col_emptied_line, pressure_sense, media_detected;
    logic eject_done, window_relay, window_motor_up, window_motor_down;
    logic arm, saw_valve, saw_take, saw_wind, saw_off, saw_line, bad_down, bad_press;
    logic tape_prev, media_prev, right_prev, right_at_fall;
    int err_total, compares, n, done_cnt, cyc_no, t_fall, t_media;
    tus_row_t r;
    // fields: variant, host start, raise by reset button, operator flag expected
    tus_row_t rows [4] = '{4'b0001, 4'b1011, 4'b0110, 4'b1100};
    tus_unload_seq DUT (.*);
    tus_plant plant (.*);
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic timed_out(input string what);
        err_total++;
        $display("[ERR] %s expected done seen timeout", what);
        test_done();
    endtask
    always @(negedge ref_clk) begin
        cyc_no++;
        if (arm === 1'b1) begin
            saw_valve |= transfer_valve === 1'b1;
            saw_take |= (left_reel_cw & ~right_reel_ccw) === 1'b1;
            saw_wind |= (left_reel_ccw & right_reel_ccw) === 1'b1;
            saw_off |= (eject_in_progress & ~pneumatic_motor) === 1'b1;
            saw_line |= col_emptied_line === 1'b1;
            bad_down |= (eject_in_progress & window_motor_down) === 1'b1;
            bad_press |= (~pneumatic_motor & pressure_sense) === 1'b1;
            if (tape_prev === 1'b1 && tape_end_marker_sensor === 1'b0) t_fall = cyc_no;
            if (media_prev === 1'b1 && media_detected === 1'b0) begin
                t_media = cyc_no;
                right_at_fall = right_prev;
            end
            if (eject_done === 1'b1) begin
                done_cnt++;
                chk("columns_empty at done", columns_empty, 1'b1);
                chk("media_detected at done", media_detected, 1'b0);
            end
        end
        tape_prev = tape_end_marker_sensor;
        media_prev = media_detected;
        right_prev = right_reel_ccw;
    end
    initial begin
        {arm, eject_button, host_unload_cmd, thread_button, reset_button, early_drop_cfg, safety_bail_sw} = '0;
        reset = 1'b1;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            @(posedge ref_clk);
            {thread_button, reset_button, early_drop_cfg} <= {!r.up_by_reset, r.up_by_reset, r.cfg};
            @(posedge ref_clk);
            {thread_button, reset_button} <= 2'b00;
            for (n = 0; n < LIM && door_top_limit_sw !== 1'b1; n++) @(negedge ref_clk);
            if (n == LIM) timed_out("window up");
            repeat (3) @(negedge ref_clk);
            chk("window_relay up", window_relay, 1'b1);
            chk("window_motor_up at top", window_motor_up, 1'b0);
            chk("media_detected loaded", media_detected, 1'b1);
            {saw_valve, saw_take, saw_wind, saw_off, saw_line, bad_down, bad_press, done_cnt} = '0;
            arm = 1'b1;
            @(posedge ref_clk);
            {eject_button, host_unload_cmd} <= {!r.by_host, r.by_host};
            @(posedge ref_clk);
            {eject_button, host_unload_cmd} <= 2'b00;
            for (n = 0; n < 4 && eject_in_progress !== 1'b1; n++) @(negedge ref_clk);
            if (n == 4) timed_out("start");
            chk("eject_in_progress", eject_in_progress, 1'b1);
            chk("eject_rewind_flag", eject_rewind_flag, 1'b1);
            chk("operator_initiated", operator_initiated, r.exp_oper);
            chk("right_reel_ccw", right_reel_ccw, 1'b1);
            chk("window_relay released", window_relay, 1'b0);
            chk("col_emptied_line early", col_emptied_line, 1'b0);
            // second start while busy, and the variant input flips under the running sequence
            @(posedge ref_clk);
            {eject_button, early_drop_cfg} <= {1'b1, !r.cfg};
            @(posedge ref_clk);
            eject_button <= 1'b0;
            for (n = 0; n < LIM && done_cnt == 0; n++) @(negedge ref_clk);
            if (n == LIM) timed_out("unload");
            repeat (3) @(negedge ref_clk);
            chk("done pulses", 16'(done_cnt), 16'h0001);
            chk("in progress cleared", eject_in_progress, 1'b0);
            chk("transfer valve used", saw_valve, 1'b1);
            chk("left takeup alone", saw_take, 1'b1);
            chk("both reels ccw", saw_wind, 1'b1);
            chk("pneumatics dropped", saw_off, r.cfg);
            chk("column line rose", saw_line, 1'b1);
            chk("tail delay in range", 16'(t_media - t_fall >= TAPE_TAIL_CYC && t_media - t_fall <= TAPE_TAIL_CYC + 2), 16'h0001);
            chk("right reel during tail", right_at_fall, 1'b1);
            chk("lowered while busy", bad_down, 1'b0);
            chk("pressure with pump off", bad_press, 1'b0);
            for (n = 0; n < LIM && door_bottom_limit_sw !== 1'b1; n++) @(negedge ref_clk);
            if (n == LIM) timed_out("window down");
            repeat (3) @(negedge ref_clk);
            chk("motor_down at bottom", window_motor_down, 1'b0);
            arm = 1'b0;
            @(posedge ref_clk);
            reset <= 1'b1;
            repeat (2) @(posedge ref_clk);
            reset <= 1'b0;
            $display("row %0d finished", i);
        end
        // safety bail while the window is still rising
        @(posedge ref_clk);
        thread_button <= 1'b1;
        @(posedge ref_clk);
        thread_button <= 1'b0;
        repeat (4) @(posedge ref_clk);
        safety_bail_sw <= 1'b1;
        repeat (2) @(posedge ref_clk);
        safety_bail_sw <= 1'b0;
        for (n = 0; n < 4 && window_motor_down !== 1'b1; n++) @(negedge ref_clk);
        if (n == 4) timed_out("bail lowering");
        chk("bail relay", window_relay, 1'b0);
        chk("bail motor_down", window_motor_down, 1'b1);
        chk("bail motor_up", window_motor_up, 1'b0);
        for (n = 0; n < LIM && door_bottom_limit_sw !== 1'b1; n++) @(negedge ref_clk);
        if (n == LIM) timed_out("bail lower");
        $display("bail test finished");
        // reset in the middle of an unload
        @(posedge ref_clk);
        eject_button <= 1'b1;
        @(posedge ref_clk);
        eject_button <= 1'b0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b1;
        repeat (10) @(negedge ref_clk);
        chk("outputs in reset", {eject_in_progress, eject_rewind_flag, operator_initiated, right_reel_ccw,
            left_reel_cw, left_reel_ccw, transfer_valve, pneumatic_motor, columns_empty, col_emptied_line,
            pressure_sense, media_detected, eject_done, window_relay, window_motor_up, window_motor_down}, 16'h0000);
        @(posedge ref_clk);
        reset <= 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("idle after reset", eject_in_progress, 1'b0);
        $display("reset test finished");
        test_done();
    end
endmodule
`default_nettype wire
